// *** ffeh_pkg.sv ***
package ffeh_pkg;
  // object dictionary addressing
  localparam logic [15:0] IDX_SUMMARY = 16'h1001;
  localparam logic [15:0] IDX_HISTORY = 16'h1003;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_FIRST = 8'h01;
  localparam int HIST_DEPTH_DEF = 8;

  // reset values
  localparam logic [7:0] SUMMARY_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [31:0] ENTRY_RESET = 32'h00000000;

  // summary byte bit positions
  localparam int BIT_GENERAL = 0;
  localparam int BIT_CURRENT = 1;
  localparam int BIT_VOLTAGE = 2;
  localparam int BIT_TEMPERATURE = 3;
  localparam int BIT_LINK = 4;
  localparam int BIT_DRIVE_STD = 5;
  localparam int BIT_UNUSED6 = 6;
  localparam int BIT_VENDOR = 7;
  localparam logic [7:0] SUMMARY_MASK = 8'hbf;

  // transfer abort codes
  localparam logic [31:0] ABORT_NO_DATA = 32'h08000024;
  localparam logic [31:0] ABORT_READ_ONLY = 32'h06010002;
  localparam logic [31:0] ABORT_NO_OBJECT = 32'h06020000;
  localparam logic [31:0] ABORT_NO_SUB = 32'h06090011;
  localparam logic [31:0] ABORT_BAD_VALUE = 32'h06090030;

  // fault numbers
  localparam logic [7:0] FN_WATCHDOG = 8'h00;
  localparam logic [7:0] FN_SUPPLY_HIGH = 8'h01;
  localparam logic [7:0] FN_OUT_CURRENT = 8'h02;
  localparam logic [7:0] FN_SUPPLY_LOW = 8'h03;
  localparam logic [7:0] FN_FIELDBUS = 8'h04;
  localparam logic [7:0] FN_GUARD_LATE = 8'h06;
  localparam logic [7:0] FN_SENSOR1 = 8'h07;
  localparam logic [7:0] FN_SENSOR2 = 8'h08;
  localparam logic [7:0] FN_SENSOR3 = 8'h09;
  localparam logic [7:0] FN_LIMIT_POS = 8'h0a;
  localparam logic [7:0] FN_LIMIT_NEG = 8'h0b;
  localparam logic [7:0] FN_OVERTEMP = 8'h0c;

  // standard error codes
  localparam logic [15:0] EC_NONE = 16'h0000;
  localparam logic [15:0] EC_GENERAL = 16'h1000;
  localparam logic [15:0] EC_CURRENT = 16'h2300;
  localparam logic [15:0] EC_VOLTAGE = 16'h3100;
  localparam logic [15:0] EC_TEMP = 16'h4200;
  localparam logic [15:0] EC_WATCHDOG = 16'h6010;
  localparam logic [15:0] EC_SENSOR1 = 16'h7305;
  localparam logic [15:0] EC_SENSOR2 = 16'h7306;

  typedef struct packed {
    logic write;
    logic [15:0] index;
    logic [7:0] subindex;
    logic [31:0] wdata;
  } ffeh_req_type;

  typedef struct packed {
    logic abort;
    logic [31:0] data;
  } ffeh_resp_type;

  // history word: number [31:24], class [23:16], code [15:0]
  typedef struct packed {
    logic [7:0] number;
    logic [7:0] class_byte;
    logic [15:0] code;
  } ffeh_entry_type;
endpackage : ffeh_pkg

// *** ffeh_top.sv ***
`timescale 1ns/1ps
// How it works
// [R01] eight read-only 32-bit history entries; writes to them are refused
// [R02] new fault enters entry 1, older entries shift down, oldest dropped
// [R03] 8-bit count at sub-entry 0, readable and writable, zero after reset
// [R04] reading entries 1-8 while empty aborts with code 08000024h
// [R05] writing zero to the count restarts counting and empties the history
// [R06] summary byte bit layout fixed; bit 6 always reads zero
// [R07] each entry carries an 8-bit fault number field
// [R08] fault numbers 0-4: watchdog, supply high, current, supply low, fieldbus
// [R09] fault number 6 means the master's node-guarding request came late
// [R10] numbers 7-9 sensors, 10-11 limit switches, 12 overtemperature
// [R11] entry 1 holds the newest fault and is zero after reset
// [R12] summary bits follow their fault classes and clear by themselves
// [R13] entry class byte equals the summary byte at logging time
// [R14] entry holds a 16-bit standard error code such as 2300h or 3100h
// [R15] each push increments the count, saturating at eight
module ffeh_top #(
  parameter int HIST_DEPTH = ffeh_pkg::HIST_DEPTH_DEF
) (
  input wire logic clk_sys, // system clock, 200 MHz
  input wire logic rstn, // asynchronous reset, active low
  input wire logic req_valid, // one-cycle object access request
  input wire ffeh_pkg::ffeh_req_type req, // access index, subindex, data
  input wire logic [7:0] fault_class_in, // live fault class levels
  input wire logic fault_push, // one-cycle new fault event
  input wire logic [7:0] fault_number, // cause of the new fault
  input wire logic [15:0] fault_code, // standard code, zero selects default
  output logic resp_valid, // one-cycle answer strobe
  output ffeh_pkg::ffeh_resp_type resp, // read data or abort code
  output logic [7:0] summary_flags, // fault summary byte
  output logic [7:0] history_count // logged fault count
);

  // subindex is 8 bits and the count must fit it; refused at elaboration
  if (HIST_DEPTH < 1 || HIST_DEPTH > 254) begin : g_depth_check
    $error("ffeh_top: HIST_DEPTH out of range");
  end

  localparam logic [7:0] DEPTH_B = 8'(HIST_DEPTH);

  logic resp_valid_ff;
  ffeh_pkg::ffeh_resp_type resp_ff;
  ffeh_pkg::ffeh_resp_type nxt_resp;
  logic [7:0] summary_ff;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [31:0] hist_ff [HIST_DEPTH];
  logic restart;
  logic is_hist_sub;
  ffeh_pkg::ffeh_entry_type new_entry;

  // default standard code when the reporter gives none
  function automatic logic [15:0] ffeh_std_code(input logic [7:0] num);
    logic [15:0] c;
    c = ffeh_pkg::EC_GENERAL;
    unique case (num)
      ffeh_pkg::FN_WATCHDOG: c = ffeh_pkg::EC_WATCHDOG; // R08
      ffeh_pkg::FN_SUPPLY_HIGH: c = ffeh_pkg::EC_VOLTAGE; // R08 R14
      ffeh_pkg::FN_SUPPLY_LOW: c = ffeh_pkg::EC_VOLTAGE; // R08 R14
      ffeh_pkg::FN_OUT_CURRENT: c = ffeh_pkg::EC_CURRENT; // R08 R14
      ffeh_pkg::FN_FIELDBUS: c = ffeh_pkg::EC_GENERAL; // R08
      ffeh_pkg::FN_GUARD_LATE: c = ffeh_pkg::EC_GENERAL; // R09
      ffeh_pkg::FN_SENSOR1: c = ffeh_pkg::EC_SENSOR1; // R10
      ffeh_pkg::FN_SENSOR2: c = ffeh_pkg::EC_SENSOR2; // R10
      ffeh_pkg::FN_OVERTEMP: c = ffeh_pkg::EC_TEMP; // R10
      default: c = ffeh_pkg::EC_GENERAL; // R10
    endcase
    return c;
  endfunction : ffeh_std_code

  // word to log: number, summary snapshot, code
  always_comb begin
    new_entry.number = fault_number; // R07
    new_entry.class_byte = summary_ff; // R13
    new_entry.code = (fault_code == ffeh_pkg::EC_NONE) ?
                     ffeh_std_code(fault_number) : fault_code; // R14
  end

  // a zero written to the count restarts the history
  assign restart = req_valid && req.write && req.index == ffeh_pkg::IDX_HISTORY &&
                   req.subindex == ffeh_pkg::SUB_COUNT && req.wdata == 32'h00000000; // R05
  assign is_hist_sub = req.subindex >= ffeh_pkg::SUB_FIRST && req.subindex <= DEPTH_B;

  // summary follows class levels one cycle late; bit 6 masked off
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      summary_ff <= ffeh_pkg::SUMMARY_RESET;
    end else begin
      summary_ff <= fault_class_in & ffeh_pkg::SUMMARY_MASK; // R06 R12
    end
  end

  // history stack; a push in the restart cycle still lands, on an empty stack
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist_ff[i] <= ffeh_pkg::ENTRY_RESET; // R11
      end
    end else if (fault_push) begin
      hist_ff[0] <= new_entry; // R02 R11
      for (int i = 1; i < HIST_DEPTH; i++) begin
        hist_ff[i] <= restart ? ffeh_pkg::ENTRY_RESET : hist_ff[i-1]; // R02
      end
    end else if (restart) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist_ff[i] <= ffeh_pkg::ENTRY_RESET; // R05
      end
    end
  end

  // count: a push in the restart cycle sets it to one, so no fault is lost
  always_comb begin
    nxt_cnt = cnt_ff;
    if (fault_push) begin
      if (restart) begin
        nxt_cnt = 8'h01; // R05
      end else if (cnt_ff < DEPTH_B) begin
        nxt_cnt = cnt_ff + 8'h01; // R15
      end
    end else if (restart) begin
      nxt_cnt = ffeh_pkg::COUNT_RESET; // R05
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= ffeh_pkg::COUNT_RESET; // R03
    end else begin
      cnt_ff <= nxt_cnt; // R03
    end
  end

  // access decode; reads see state before this cycle's push
  always_comb begin
    nxt_resp.abort = 1'b0;
    nxt_resp.data = 32'h00000000;
    if (req.index == ffeh_pkg::IDX_SUMMARY) begin
      if (req.subindex != ffeh_pkg::SUB_COUNT) begin
        nxt_resp = '{abort: 1'b1, data: ffeh_pkg::ABORT_NO_SUB};
      end else if (req.write) begin
        nxt_resp = '{abort: 1'b1, data: ffeh_pkg::ABORT_READ_ONLY};
      end else begin
        nxt_resp.data = {24'h000000, summary_ff}; // R06
      end
    end else if (req.index == ffeh_pkg::IDX_HISTORY) begin
      if (req.subindex == ffeh_pkg::SUB_COUNT) begin
        if (req.write && req.wdata != 32'h00000000) begin
          nxt_resp = '{abort: 1'b1, data: ffeh_pkg::ABORT_BAD_VALUE};
        end else if (!req.write) begin
          nxt_resp.data = {24'h000000, cnt_ff}; // R03
        end
      end else if (!is_hist_sub) begin
        nxt_resp = '{abort: 1'b1, data: ffeh_pkg::ABORT_NO_SUB};
      end else if (req.write) begin
        nxt_resp = '{abort: 1'b1, data: ffeh_pkg::ABORT_READ_ONLY}; // R01
      end else if (cnt_ff == ffeh_pkg::COUNT_RESET) begin
        nxt_resp = '{abort: 1'b1, data: ffeh_pkg::ABORT_NO_DATA}; // R04
      end else begin
        for (int i = 0; i < HIST_DEPTH; i++) begin
          if (req.subindex == 8'(i + 1)) begin
            nxt_resp.data = hist_ff[i]; // R01 R11
          end
        end
      end
    end else begin
      nxt_resp = '{abort: 1'b1, data: ffeh_pkg::ABORT_NO_OBJECT};
    end
  end

  // answer one cycle after the request, held until the next one
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      resp_valid_ff <= 1'b0;
      resp_ff <= '0;
    end else begin
      resp_valid_ff <= req_valid;
      if (req_valid) begin
        resp_ff <= nxt_resp;
      end
    end
  end

  assign resp_valid = resp_valid_ff;
  assign resp = resp_ff;
  assign summary_flags = summary_ff;
  assign history_count = cnt_ff;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  logic rd_hist;
  assign rd_hist = req_valid && !req.write && req.index == ffeh_pkg::IDX_HISTORY && is_hist_sub;

  a_resp_timing: assert property (req_valid |=> resp_valid ##1 !resp_valid || $past(req_valid))
    else $error("answer strobe not one cycle after request");
  a_empty_abort: assert property (rd_hist && cnt_ff == 8'h00 |=> // R04
    resp.abort && resp.data == ffeh_pkg::ABORT_NO_DATA)
    else $error("empty history read not aborted");
  a_entry_readonly: assert property (req_valid && req.write && !fault_push && // R01
    req.index == ffeh_pkg::IDX_HISTORY && is_hist_sub |=> resp.abort && cnt_ff == $past(cnt_ff))
    else $error("write to history entry accepted");
  a_push_top: assert property (fault_push |=> // R02
    hist_ff[0][31:24] == $past(fault_number) && hist_ff[0][23:16] == $past(summary_ff))
    else $error("new fault not in first entry");
  a_shift_down: assert property (fault_push && !restart |=> hist_ff[HIST_DEPTH-1] == // R02
    $past(hist_ff[(HIST_DEPTH > 1) ? HIST_DEPTH - 2 : 0]) || HIST_DEPTH == 1)
    else $error("history did not shift");
  a_count_inc: assert property (fault_push && !restart && cnt_ff < DEPTH_B |=> // R15
    cnt_ff == $past(cnt_ff) + 8'h01)
    else $error("count did not increment");
  a_count_sat: assert property (cnt_ff <= DEPTH_B) // R15
    else $error("count above depth");
  a_restart_empty: assert property (restart && !fault_push |=> // R05
    cnt_ff == 8'h00 && hist_ff[0] == 32'h00000000)
    else $error("restart did not empty history");
  a_unused_zero: assert property (summary_flags[ffeh_pkg::BIT_UNUSED6] == 1'b0) // R06
    else $error("reserved summary bit set");
  a_flag_clears: assert property (!fault_class_in[ffeh_pkg::BIT_CURRENT] |=> // R12
    !summary_flags[ffeh_pkg::BIT_CURRENT])
    else $error("summary flag did not clear");
  a_first_read: assert property (rd_hist && req.subindex == ffeh_pkg::SUB_FIRST && // R11
    cnt_ff != 8'h00 |=> !resp.abort && resp.data == $past(hist_ff[0]))
    else $error("first entry read wrong");

  // entry fields seen through the stored word layout
  ffeh_pkg::ffeh_entry_type top_entry;
  assign top_entry = hist_ff[0];

  // summary copy; the first edge after reset still sees reset-time inputs
  a_summary_copy: assert property ($past(rstn) |-> // R12
    summary_flags == ($past(fault_class_in) & ffeh_pkg::SUMMARY_MASK))
    else $error("summary byte does not follow fault classes");

  // standard code: a given code is kept, a zero code takes the default
  a_code_given: assert property (fault_push && fault_code != ffeh_pkg::EC_NONE |=> // R14
    top_entry.code == $past(fault_code))
    else $error("given error code not stored");
  a_code_current: assert property (fault_push && fault_code == ffeh_pkg::EC_NONE && // R14
    fault_number == ffeh_pkg::FN_OUT_CURRENT |=> top_entry.code == ffeh_pkg::EC_CURRENT)
    else $error("current fault code wrong");
  a_code_supply: assert property (fault_push && fault_code == ffeh_pkg::EC_NONE && // R14
    (fault_number == ffeh_pkg::FN_SUPPLY_HIGH || fault_number == ffeh_pkg::FN_SUPPLY_LOW)
    |=> top_entry.code == ffeh_pkg::EC_VOLTAGE)
    else $error("supply fault code wrong");
  a_code_watchdog: assert property (fault_push && fault_code == ffeh_pkg::EC_NONE && // R08
    fault_number == ffeh_pkg::FN_WATCHDOG |=> top_entry.code == ffeh_pkg::EC_WATCHDOG)
    else $error("watchdog fault code wrong");
  a_code_temp: assert property (fault_push && fault_code == ffeh_pkg::EC_NONE && // R10
    fault_number == ffeh_pkg::FN_OVERTEMP |=> top_entry.code == ffeh_pkg::EC_TEMP)
    else $error("overtemperature fault code wrong");

  // the old first entry moves one place down on every push without a restart
  a_second_shift: assert property (fault_push && !restart |=> HIST_DEPTH == 1 || // R02
    hist_ff[(HIST_DEPTH > 1) ? 1 : 0] == $past(hist_ff[0]))
    else $error("first entry not moved down");

  // only a push or a restart may change the stack or the count
  a_stack_hold: assert property (!fault_push && !restart |=> // R01
    hist_ff[0] == $past(hist_ff[0]) && hist_ff[HIST_DEPTH-1] == $past(hist_ff[HIST_DEPTH-1]))
    else $error("history changed without a push");
  a_count_hold: assert property (!fault_push && !restart |=> cnt_ff == $past(cnt_ff)) // R03
    else $error("count changed without a push");
  a_count_full: assert property (fault_push && !restart && cnt_ff == DEPTH_B |=> // R15
    cnt_ff == DEPTH_B)
    else $error("count passed the stack depth");

  // a push meeting a restart is kept rather than lost
  a_restart_push: assert property (fault_push && restart |=> cnt_ff == 8'h01 && // R05
    top_entry.number == $past(fault_number) &&
    (HIST_DEPTH == 1 || hist_ff[HIST_DEPTH-1] == ffeh_pkg::ENTRY_RESET))
    else $error("restart with push left stale entries");

  // answers of the count and summary objects and of missing sub-entries
  logic rd_count;
  assign rd_count = req_valid && !req.write && req.index == ffeh_pkg::IDX_HISTORY &&
                    req.subindex == ffeh_pkg::SUB_COUNT;
  a_count_read: assert property (rd_count |=> // R03
    !resp.abort && resp.data == {24'h000000, $past(cnt_ff)})
    else $error("count read wrong");
  a_count_reject: assert property (req_valid && req.write && // R05
    req.index == ffeh_pkg::IDX_HISTORY && req.subindex == ffeh_pkg::SUB_COUNT &&
    req.wdata != 32'h00000000 |=> resp.abort && resp.data == ffeh_pkg::ABORT_BAD_VALUE)
    else $error("nonzero count write accepted");
  a_summary_ro: assert property (req_valid && req.write && // R06
    req.index == ffeh_pkg::IDX_SUMMARY |=> resp.abort)
    else $error("summary byte write accepted");
  a_restart_ack: assert property (restart |=> !resp.abort && resp.data == 32'h00000000) // R05
    else $error("count restart not acknowledged");
  a_sub_range: assert property (req_valid && req.index == ffeh_pkg::IDX_HISTORY && // R01
    req.subindex > DEPTH_B |=> resp.abort && resp.data == ffeh_pkg::ABORT_NO_SUB)
    else $error("read beyond the stack not refused");

  // answer stands until the next request is taken
  a_answer_hold: assert property (!req_valid |=>
    !resp_valid && resp == $past(resp))
    else $error("answer changed without a request");

  c_push: cover property (fault_push ##1 rd_hist);
  c_restart: cover property (restart);
  c_empty_abort: cover property (rd_hist && cnt_ff == 8'h00);
  c_full: cover property (cnt_ff == DEPTH_B && fault_push);
  c_collide: cover property (restart && fault_push);

endmodule : ffeh_top

// *** ffeh_master.sv ***
`timescale 1ns/1ps
// network master issuing one object access at a time
module ffeh_master (
  input wire logic clk_sys, // system clock
  input wire logic resp_valid, // answer strobe
  input wire ffeh_pkg::ffeh_resp_type resp, // answer body
  output logic req_valid, // request strobe
  output ffeh_pkg::ffeh_req_type req // request body
);
  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // one-cycle request, answer expected exactly one edge later
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] wd, output logic [32:0] got);
    @(negedge clk_sys);
    req_valid = 1'b1;
    req = '{wr, idx, sub, wd};
    @(negedge clk_sys);
    req_valid = 1'b0;
    req = ~req; // released lines must not look valid
    got = {resp.abort, resp.data};
    if (resp_valid !== 1'b1) begin
      got = 33'hx; // late or missing answer never matches
    end
  endtask : access
endmodule : ffeh_master

// *** tb_fault_flags_and_error_history.sv ***
`timescale 1ns/1ps
module tb_fault_flags_and_error_history;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic fault_push = 1'b0;
  logic [7:0] fault_class_in = 8'h00;
  logic [7:0] fault_number = 8'h00;
  logic [15:0] fault_code = 16'h0000;
  logic req_valid;
  logic resp_valid;
  ffeh_pkg::ffeh_req_type req;
  ffeh_pkg::ffeh_resp_type resp;
  logic [7:0] summary_flags;
  logic [7:0] history_count;
  logic [31:0] exp_q [1:8];
  logic [7:0] nums [0:11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06,
                              8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c};
  int err_total = 0;
  int comparisons = 0;

  always #2.5 clk_sys = ~clk_sys;

  ffeh_master mst (.clk_sys(clk_sys), .resp_valid(resp_valid), .resp(resp),
                   .req_valid(req_valid), .req(req));
  ffeh_top #(.HIST_DEPTH(8)) dut (.clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid),
    .req(req), .fault_class_in(fault_class_in), .fault_push(fault_push),
    .fault_number(fault_number), .fault_code(fault_code), .resp_valid(resp_valid),
    .resp(resp), .summary_flags(summary_flags), .history_count(history_count));

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // access plus compare of abort flag and data together
  task automatic obj(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] wd, input logic [32:0] exp);
    logic [32:0] got;
    mst.access(wr, idx, sub, wd, got);
    chk(got, exp);
  endtask : obj

  // push on consecutive cycles; the model stack shifts alongside
  task automatic push(input logic [7:0] num, input logic [15:0] code, input logic [31:0] word);
    @(negedge clk_sys);
    fault_push = 1'b1;
    fault_number = num;
    fault_code = code;
    for (int k = 8; k > 1; k--) exp_q[k] = exp_q[k - 1];
    exp_q[1] = word;
  endtask : push

  task automatic t_reset;
    chk({25'h0, history_count}, 33'h0);
    obj(1'b0, 16'h1003, 8'h00, 32'h0, 33'h000000000);
    obj(1'b0, 16'h1001, 8'h00, 32'h0, 33'h000000000);
    obj(1'b0, 16'h1003, 8'h01, 32'h0, 33'h108000024);
    obj(1'b0, 16'h1003, 8'h08, 32'h0, 33'h108000024);
    obj(1'b0, 16'h2000, 8'h00, 32'h0, 33'h106020000);
  endtask : t_reset

  task automatic t_summary;
    fault_class_in = 8'hff;
    repeat (2) @(negedge clk_sys);
    chk({25'h0, summary_flags}, 33'hbf);
    obj(1'b0, 16'h1001, 8'h00, 32'h0, 33'h0000000bf);
    fault_class_in = 8'h00;
    repeat (2) @(negedge clk_sys);
    chk({25'h0, summary_flags}, 33'h0);
  endtask : t_summary

  // twelve back-to-back faults overflow the eight-deep stack
  task automatic t_burst;
    fault_class_in = 8'h05;
    @(negedge clk_sys);
    for (int i = 0; i < 12; i++) push(nums[i], {8'ha0, 8'(i)}, {nums[i], 8'h05, 8'ha0, 8'(i)});
    @(negedge clk_sys);
    fault_push = 1'b0;
    fault_number = 8'hff;
    chk({25'h0, history_count}, 33'h8);
    obj(1'b0, 16'h1003, 8'h00, 32'h0, 33'h000000008);
    for (int k = 1; k <= 8; k++) obj(1'b0, 16'h1003, 8'(k), 32'h0, {1'b0, exp_q[k]});
  endtask : t_burst

  task automatic t_refuse;
    obj(1'b1, 16'h1003, 8'h01, 32'h1, 33'h106010002);
    obj(1'b0, 16'h1003, 8'h09, 32'h0, 33'h106090011);
    obj(1'b0, 16'h1001, 8'h01, 32'h0, 33'h106090011);
    obj(1'b1, 16'h1001, 8'h00, 32'h1, 33'h106010002);
    obj(1'b1, 16'h1003, 8'h00, 32'h5, 33'h106090030);
    obj(1'b0, 16'h1003, 8'h00, 32'h0, 33'h000000008);
    obj(1'b1, 16'h1003, 8'h00, 32'h0, 33'h000000000);
    chk({25'h0, history_count}, 33'h0);
    obj(1'b0, 16'h1003, 8'h01, 32'h0, 33'h108000024);
  endtask : t_refuse

  // zero code selects the standard code of the fault number
  task automatic t_codes;
    fault_class_in = 8'h02;
    @(negedge clk_sys);
    push(8'h02, 16'h0000, 32'h02022300);
    push(8'h03, 16'h0000, 32'h03023100);
    @(negedge clk_sys);
    fault_push = 1'b0;
    chk({25'h0, history_count}, 33'h2);
    obj(1'b0, 16'h1003, 8'h01, 32'h0, 33'h003023100);
    obj(1'b0, 16'h1003, 8'h02, 32'h0, 33'h002022300);
    obj(1'b0, 16'h1003, 8'h03, 32'h0, 33'h000000000);
  endtask : t_codes

  // a push in the restart cycle is kept as the only logged fault
  task automatic t_collide;
    logic [32:0] got;
    fork
      mst.access(1'b1, 16'h1003, 8'h00, 32'h0, got);
      push(8'h0c, 16'h0000, 32'h0c024200);
    join
    fault_push = 1'b0;
    chk(got, 33'h000000000);
    chk({25'h0, history_count}, 33'h1);
    obj(1'b0, 16'h1003, 8'h01, 32'h0, 33'h00c024200);
    obj(1'b0, 16'h1003, 8'h02, 32'h0, 33'h000000000);
  endtask : t_collide

  task automatic report_and_stop;
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // the whole run takes under a hundred cycles
  initial begin
    #20000;
    err_total++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    t_reset();
    t_summary();
    t_burst();
    t_refuse();
    t_codes();
    t_collide();
    report_and_stop();
  end
endmodule : tb_fault_flags_and_error_history
